// ==== src/irq_lowpower_cfg.svh ====
// Register indices, field positions, vectors and reset values
`ifndef IRQ_LOWPOWER_CFG_SVH
`define IRQ_LOWPOWER_CFG_SVH

// ==========================================================
// Register indices (byte address is four times the index)
`define IDX_PORT_CFG 8'h03
`define IDX_CORE_TICK 8'h08
`define IDX_TIMER_CTRL 8'h12
`define IDX_TIMER_STAT 8'h13
`define IDX_CAN_CTRL 8'h20
`define IDX_CAN_SRC 8'h23
`define IDX_POWER_STAT 8'h40

// ==========================================================
// Field positions
`define PCR_PIN_FLAG 5
`define PCR_IMPL_MASK 8'h3f
`define CT_WRAP_FLAG 7
`define CT_RT_FLAG 6
`define CT_WRAP_EN 5
`define CT_RT_EN 4
`define CT_SEL_HI 1
`define CT_SEL_LO 0
`define CT_IMPL_MASK 8'hf3
`define CT_CLEAR_ON_STOP 8'h0f
`define TM_FLAGS_MASK 8'he0
`define TM_CTRL_MASK 8'he3
`define SRC_WAKE 4
`define SRC_OVERRUN 3
`define SRC_ERROR 2
`define SRC_TX 1
`define SRC_RX 0
`define CC_OVR_EN 4
`define CC_ERR_EN 3
`define CC_TX_EN 2
`define CC_RX_EN 1

// ==========================================================
// Reset values
`define RST_PORT_CFG 8'h00
`define RST_CORE_TICK 8'h03
`define RST_ZERO8 8'h00
`define RST_CAN_CTRL 8'h01

// ==========================================================
// Vectors (high byte address; VEC_RESET_LO is the low byte)
`define VEC_RESET_HI 16'h1ffe
`define VEC_RESET_LO 16'h1fff
`define VEC_SWI 16'h1ffc
`define VEC_CAN 16'h1ffa
`define VEC_CORE_TICK 16'h1ff8
`define VEC_PIN_OR 16'h1ff6
`define VEC_TIMER 16'h1ff4

// ==========================================================
// Bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ==== src/irq_lowpower_pkg.sv ====
// Types shared by the interrupt and low-power controller
package irq_lowpower_pkg;

  // ==========================================================
  // AXI4-Lite carriers
  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } axi_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axi_rsp_t;

  // ==========================================================
  // Processor power state
  typedef enum logic [2:0] {
    RESET_HI, RESET_LO, RUN, WAITING, STOPPED
  } power_state_t;

endpackage

// ==== src/irq_lowpower_control.sv ====
// Interrupt request, vector and STOP/WAIT control for the processor core
// Overview of operation
// - CAN source identity readable in the source register at index 23.
// - CAN sources gated by control enables; wake-up always enabled.
// - Receive and transmit sources set on complete successful messages.
// - Error source set when error or bus status bit changes.
// - Overrun source set when both receive buffers are occupied.
// - Wake-up source set on bus activity while CAN sleeps.
// - All CAN sources share the vector at 1FFA/1FFB.
// - Enabled pin driven high requests an external interrupt.
// - Pin request latched on rising edge, synchronised, vector 1FF6/1FF7.
// - Pin latch flag is port config bit 5; writing zero clears.
// - Latched pin interrupt wakes the processor from STOP.
// - Core timer requests on enabled real-time or wrap flag; 1FF8.
// - Wrap flag on FF to 00; real-time flag after selected counts.
// - Programmable timer requests on enabled capture/compare/wrap; 1FF4.
// - Reset loads vector 1FFE then 1FFF and sets the mask.
// - STOP halts oscillator only if CAN sleeps, else processor and timer clocks.
// - With oscillator stopped, timers and watchdog halt.
// - STOP entry clears timer flags, enables, prescaler and mask; rate selects kept.
// - STOP entry clears mask; exit only on CAN, pin or reset.
// - WAIT stops processor clocks, timers run; exits on enabled requests.
// - WAIT entry clears mask; other state kept.
// - Requests taken after instruction completes, when unmasked and enabled.
// - Priority: software trap, CAN, core timer, pin, programmable timer.
`timescale 1ns/10ps
`include "irq_lowpower_cfg.svh"

module irq_lowpower_control #(
  parameter int PIN_COUNT = 8
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire irq_lowpower_pkg::axi_req_t axiReq,
  output irq_lowpower_pkg::axi_rsp_t axiRsp,
  input wire logic canRxDone,
  input wire logic canTxDone,
  input wire logic canErrStatus,
  input wire logic canBusStatus,
  input wire logic canOverrun,
  input wire logic canBusActivity,
  input wire logic canAsleep,
  input wire logic [PIN_COUNT-1:0] pinIn,
  input wire logic [PIN_COUNT-1:0] pinOrEnable,
  input wire logic coreTick,
  input wire logic captureEvent,
  input wire logic compareEvent,
  input wire logic timerWrapEvent,
  input wire logic cpuInstrDone,
  input wire logic swiReq,
  input wire logic cpuStopReq,
  input wire logic cpuWaitReq,
  input wire logic cpuMaskSet,
  input wire logic cpuMaskClear,
  output logic can_irq,
  output logic [15:0] vectorAddr,
  output logic vectorLoad,
  output logic irqMask,
  output logic cpuClkEnable,
  output logic oscEnable,
  output logic timerClkEnable,
  output logic watchdogRun,
  output logic prescalerClear
);

  if (PIN_COUNT < 1 || PIN_COUNT > 16) begin : g_pin_check
    $error("PIN_COUNT must lie between 1 and 16");
  end

  // ==========================================================
  // Helpers
  function automatic logic [7:0] rtMask(input logic [1:0] sel);
    rtMask = (8'h0f << sel) | 8'h0f;
  endfunction

  function automatic logic isIdx(input logic [11:0] addr,
                                 input logic [7:0] idx);
    isIdx = (addr[11:10] == 2'b00) && (addr[9:2] == idx);
  endfunction

  // ==========================================================
  // State
  irq_lowpower_pkg::power_state_t state;
  logic [7:0] portCfg;
  logic [7:0] coreTickCtrl;
  logic [7:0] coreCount;
  logic [7:0] timerCtrl;
  logic [7:0] timerStat;
  logic [7:0] canCtrl;
  logic [4:0] canSrc;
  logic errPrev;
  logic busPrev;
  logic [PIN_COUNT-1:0] pinS1;
  logic [PIN_COUNT-1:0] pinS2;
  logic [PIN_COUNT-1:0] pinS3;
  logic [PIN_COUNT-1:0] pinStable;
  logic pinOrPrev;

  // ==========================================================
  // AXI4-Lite slave
  logic awHeld;
  logic wHeld;
  logic [11:0] awAddr;
  logic [7:0] wByte;
  logic wLane0;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;

  wire awFire = axiReq.awvalid && !awHeld && !bvalid;
  wire wFire = axiReq.wvalid && !wHeld && !bvalid;
  wire doWrite = awHeld && wHeld && !bvalid;
  wire arFire = axiReq.arvalid && !rvalid;
  wire wrOn = doWrite && wLane0;
  wire wrPcr = wrOn && isIdx(awAddr, `IDX_PORT_CFG);
  wire wrCt = wrOn && isIdx(awAddr, `IDX_CORE_TICK);
  wire wrTc = wrOn && isIdx(awAddr, `IDX_TIMER_CTRL);
  wire wrTs = wrOn && isIdx(awAddr, `IDX_TIMER_STAT);
  wire wrCc = wrOn && isIdx(awAddr, `IDX_CAN_CTRL);
  wire wrMapped = isIdx(awAddr, `IDX_PORT_CFG) ||
                  isIdx(awAddr, `IDX_CORE_TICK) ||
                  isIdx(awAddr, `IDX_TIMER_CTRL) ||
                  isIdx(awAddr, `IDX_TIMER_STAT) ||
                  isIdx(awAddr, `IDX_CAN_CTRL) ||
                  isIdx(awAddr, `IDX_CAN_SRC) ||
                  isIdx(awAddr, `IDX_POWER_STAT);
  wire rdSrc = arFire && isIdx(axiReq.araddr, `IDX_CAN_SRC);

  logic [7:0] readByte;
  logic readHit;
  always_comb begin
    readByte = 8'h00;
    readHit = 1'b1;
    case (1'b1)
      isIdx(axiReq.araddr, `IDX_PORT_CFG): readByte = portCfg;
      isIdx(axiReq.araddr, `IDX_CORE_TICK): readByte = coreTickCtrl;
      isIdx(axiReq.araddr, `IDX_TIMER_CTRL): readByte = timerCtrl;
      isIdx(axiReq.araddr, `IDX_TIMER_STAT): readByte = timerStat;
      isIdx(axiReq.araddr, `IDX_CAN_CTRL): readByte = canCtrl;
      isIdx(axiReq.araddr, `IDX_CAN_SRC): readByte = {3'h0, canSrc};
      isIdx(axiReq.araddr, `IDX_POWER_STAT):
        readByte = {3'h0, oscEnable, irqMask, 3'(state)};
      default: readHit = 1'b0;
    endcase
  end

  assign axiRsp.awready = !awHeld && !bvalid;
  assign axiRsp.wready = !wHeld && !bvalid;
  assign axiRsp.bvalid = bvalid;
  assign axiRsp.bresp = bresp;
  assign axiRsp.arready = !rvalid;
  assign axiRsp.rvalid = rvalid;
  assign axiRsp.rdata = rdata;
  assign axiRsp.rresp = rresp;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddr <= 12'h000;
      wByte <= 8'h00;
      wLane0 <= 1'b0;
      bvalid <= 1'b0;
      bresp <= `RESP_OKAY;
    end else begin
      if (awFire) begin
        awHeld <= 1'b1;
        awAddr <= axiReq.awaddr;
      end
      if (wFire) begin
        wHeld <= 1'b1;
        wByte <= axiReq.wdata[7:0];
        wLane0 <= axiReq.wstrb[0];
      end
      if (doWrite) begin
        awHeld <= 1'b0;
        wHeld <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid && axiReq.bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `RESP_OKAY;
    end else if (arFire) begin
      rvalid <= 1'b1;
      rdata <= {24'h00_0000, readByte};
      rresp <= readHit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && axiReq.rready) begin
      rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Request decoding
  wire stopped = (state == irq_lowpower_pkg::STOPPED);
  wire [4:0] canGate = {1'b1, canCtrl[`CC_OVR_EN], canCtrl[`CC_ERR_EN],
                        canCtrl[`CC_TX_EN], canCtrl[`CC_RX_EN]};
  wire canPend = |(canSrc & canGate);
  wire corePend = (coreTickCtrl[`CT_WRAP_FLAG] && coreTickCtrl[`CT_WRAP_EN]) ||
                  (coreTickCtrl[`CT_RT_FLAG] && coreTickCtrl[`CT_RT_EN]);
  wire pinPend = portCfg[`PCR_PIN_FLAG];
  wire timerPend = |(timerStat & timerCtrl & `TM_FLAGS_MASK);
  wire anyPend = canPend || corePend || pinPend || timerPend;
  wire enterStop = (state == irq_lowpower_pkg::RUN) && cpuStopReq;
  wire enterWait = (state == irq_lowpower_pkg::RUN) && !cpuStopReq &&
                   cpuWaitReq;

  // Fixed priority chain
  wire [15:0] hwVector = canPend ? `VEC_CAN :
                         corePend ? `VEC_CORE_TICK :
                         pinPend ? `VEC_PIN_OR :
                         `VEC_TIMER;
  wire runTake = (state == irq_lowpower_pkg::RUN) && cpuInstrDone &&
                 !enterStop && !enterWait &&
                 (swiReq || (!irqMask && anyPend));
  wire waitTake = (state == irq_lowpower_pkg::WAITING) && anyPend;
  wire stopTake = stopped && (canPend || pinPend);
  wire take = runTake || waitTake || stopTake;
  wire [15:0] takeVector = (runTake && swiReq) ? `VEC_SWI : hwVector;

  assign can_irq = canPend;
  assign cpuClkEnable = (state == irq_lowpower_pkg::RUN);
  assign oscEnable = !(stopped && canAsleep);
  assign timerClkEnable = !stopped;
  assign watchdogRun = oscEnable;

  // ==========================================================
  // Power state and vectors
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= irq_lowpower_pkg::RESET_HI;
      vectorAddr <= `VEC_RESET_HI;
      vectorLoad <= 1'b0;
      irqMask <= 1'b1;
      prescalerClear <= 1'b0;
    end else begin
      vectorLoad <= 1'b0;
      prescalerClear <= enterStop;
      case (state)
        irq_lowpower_pkg::RESET_HI: begin
          vectorLoad <= 1'b1;
          state <= irq_lowpower_pkg::RESET_LO;
        end
        irq_lowpower_pkg::RESET_LO: begin
          vectorLoad <= 1'b1;
          vectorAddr <= `VEC_RESET_LO;
          state <= irq_lowpower_pkg::RUN;
        end
        irq_lowpower_pkg::RUN: begin
          if (enterStop) begin
            state <= irq_lowpower_pkg::STOPPED;
          end else if (enterWait) begin
            state <= irq_lowpower_pkg::WAITING;
          end
        end
        irq_lowpower_pkg::WAITING,
        irq_lowpower_pkg::STOPPED: begin
          if (take) begin
            state <= irq_lowpower_pkg::RUN;
          end
        end
        default: state <= irq_lowpower_pkg::RUN;
      endcase
      if (take) begin
        vectorLoad <= 1'b1;
        vectorAddr <= takeVector;
        irqMask <= 1'b1;
      end else if (enterStop || enterWait) begin
        irqMask <= 1'b0;
      end else if (cpuMaskSet) begin
        irqMask <= 1'b1;
      end else if (cpuMaskClear) begin
        irqMask <= 1'b0;
      end
    end
  end

  // ==========================================================
  // CAN sources; a read clears what it returned, new events win
  wire errChange = (canErrStatus != errPrev) ||
                   (canBusStatus != busPrev);
  wire [4:0] canSet = {canBusActivity && canAsleep,
                       canOverrun,
                       errChange,
                       canTxDone, canRxDone};
  wire [4:0] canKeep = rdSrc ? 5'h00 : canSrc;

  always_ff @(posedge core_clk) begin
    errPrev <= canErrStatus;
    busPrev <= canBusStatus;
    if (srst) begin
      canSrc <= 5'h00;
      canCtrl <= `RST_CAN_CTRL;
    end else begin
      canSrc <= canSet | canKeep;
      if (wrCc) begin
        canCtrl <= wByte;
      end
    end
  end

  // ==========================================================
  // Pin wired-OR latch; three stages so a change needs two agreeing samples
  wire pinOrLevel = |(pinStable & pinOrEnable);
  wire pinRise = pinOrLevel && !pinOrPrev;
  wire pinKeep = portCfg[`PCR_PIN_FLAG] &&
                 !(wrPcr && !wByte[`PCR_PIN_FLAG]);

  always_ff @(posedge core_clk) begin
    pinS1 <= pinIn;
    pinS2 <= pinS1;
    pinS3 <= pinS2;
    if (srst) begin
      pinStable <= '0;
      pinOrPrev <= 1'b0;
      portCfg <= `RST_PORT_CFG;
    end else begin
      for (int i = 0; i < PIN_COUNT; i++) begin
        if (pinS2[i] == pinS3[i]) begin
          pinStable[i] <= pinS3[i];
        end
      end
      pinOrPrev <= pinOrLevel;
      if (wrPcr) begin
        portCfg <= wByte & `PCR_IMPL_MASK;
      end
      portCfg[`PCR_PIN_FLAG] <= pinRise || pinKeep;
    end
  end

  // ==========================================================
  // Core tick counter and flags; STOP entry clear beats a same-cycle event
  wire coreStep = coreTick && timerClkEnable;
  wire coreWrap = coreStep && (coreCount == 8'hff);
  wire rtDue = coreStep &&
               ((coreCount & rtMask(coreTickCtrl[1:0])) ==
                rtMask(coreTickCtrl[1:0]));
  wire ctWrapKeep = coreTickCtrl[`CT_WRAP_FLAG] &&
                    !(wrCt && !wByte[`CT_WRAP_FLAG]);
  wire ctRtKeep = coreTickCtrl[`CT_RT_FLAG] &&
                  !(wrCt && !wByte[`CT_RT_FLAG]);
  wire [2:0] tmEvt = {captureEvent, compareEvent, timerWrapEvent} &
                     {3{timerClkEnable}};
  wire [2:0] tmKeep = timerStat[7:5] & ~(wrTs ? ~wByte[7:5] : 3'h0);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      coreCount <= `RST_ZERO8;
      coreTickCtrl <= `RST_CORE_TICK;
      timerCtrl <= `RST_ZERO8;
      timerStat <= `RST_ZERO8;
    end else begin
      if (coreStep) begin
        coreCount <= coreCount + 8'h01;
      end
      if (enterStop) begin
        coreTickCtrl <= coreTickCtrl & `CT_CLEAR_ON_STOP;
        timerCtrl <= timerCtrl & ~`TM_FLAGS_MASK;
        timerStat <= `RST_ZERO8;
      end else begin
        if (wrCt) begin
          coreTickCtrl[`CT_WRAP_EN] <= wByte[`CT_WRAP_EN];
          coreTickCtrl[`CT_RT_EN] <= wByte[`CT_RT_EN];
          coreTickCtrl[1:0] <= wByte[1:0];
        end
        coreTickCtrl[`CT_WRAP_FLAG] <= coreWrap || ctWrapKeep;
        coreTickCtrl[`CT_RT_FLAG] <= rtDue || ctRtKeep;
        if (wrTc) begin
          timerCtrl <= wByte & `TM_CTRL_MASK;
        end
        timerStat <= {tmEvt | tmKeep, 5'h00};
      end
    end
  end

  // ==========================================================
  // Checks
  chk_reset_vector: assert property (@(posedge core_clk) disable iff (srst)
    state == irq_lowpower_pkg::RESET_HI |=> vectorLoad &&
    vectorAddr == `VEC_RESET_HI ##1 vectorLoad &&
    vectorAddr == `VEC_RESET_LO && irqMask)
    else $error("reset vector sequence wrong");

  chk_stop_osc: assert property (@(posedge core_clk) disable iff (srst)
    stopped |-> !cpuClkEnable && oscEnable != canAsleep)
    else $error("oscillator gating wrong");

  chk_stop_clears: assert property (@(posedge core_clk) disable iff (srst)
    enterStop |=> coreTickCtrl[7:4] == 4'h0 && timerStat == 8'h00 &&
    timerCtrl[7:5] == 3'h0 && prescalerClear && !irqMask)
    else $error("stop entry did not clear timer state");

  chk_stop_hold: assert property (@(posedge core_clk) disable iff (srst)
    stopped && !canPend && !pinPend |=> stopped)
    else $error("left stop without external request");

  chk_stop_wake: assert property (@(posedge core_clk) disable iff (srst)
    stopped && canPend |=> state == irq_lowpower_pkg::RUN &&
    vectorLoad && vectorAddr == `VEC_CAN)
    else $error("CAN request did not wake from stop");

  chk_wait_clocks: assert property (@(posedge core_clk) disable iff (srst)
    state == irq_lowpower_pkg::WAITING |-> timerClkEnable &&
    !cpuClkEnable && !irqMask)
    else $error("wait clocking or mask wrong");

  chk_pin_latch: assert property (@(posedge core_clk) disable iff (srst)
    $rose(pinOrLevel) |=> portCfg[`PCR_PIN_FLAG])
    else $error("pin latch flag not set");

  chk_core_wrap: assert property (@(posedge core_clk) disable iff (srst)
    coreStep && coreCount == 8'hff && !enterStop |=>
    coreCount == 8'h00 && coreTickCtrl[`CT_WRAP_FLAG])
    else $error("core wrap flag missing");

  chk_err_change: assert property (@(posedge core_clk) disable iff (srst)
    canErrStatus != $past(canErrStatus) |=> canSrc[`SRC_ERROR])
    else $error("error status change not flagged");

  chk_can_priority: assert property (@(posedge core_clk) disable iff (srst)
    runTake && !swiReq && canPend |=>
    vectorAddr == `VEC_CAN && irqMask)
    else $error("CAN not served before lower sources");

  chk_masked_hold: assert property (@(posedge core_clk) disable iff (srst)
    state == irq_lowpower_pkg::RUN && irqMask && !swiReq |=>
    !vectorLoad)
    else $error("masked request was taken");

endmodule // irq_lowpower_control

// ==== verification/cpu_core_model.sv ====
// Behavioural processor core: instruction boundaries and commands
`timescale 1ns/10ps
module cpu_core_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cpuClkEnable,
  input wire logic stopCmd,
  input wire logic waitCmd,
  input wire logic unmaskCmd,
  output logic cpuInstrDone,
  output logic cpuStopReq,
  output logic cpuWaitReq,
  output logic cpuMaskClear
);
  // ==========================================================
  // Instruction sequencer
  logic [1:0] phase;
  // Mask clear sits apart from the boundary so it never meets a take
  always_ff @(posedge core_clk) begin
    if (srst || !cpuClkEnable) begin
      phase <= 2'h0;
      cpuInstrDone <= 1'b0;
      cpuStopReq <= 1'b0;
      cpuWaitReq <= 1'b0;
      cpuMaskClear <= 1'b0;
    end else begin
      phase <= phase + 2'h1;
      cpuInstrDone <= (phase == 2'h3);
      cpuStopReq <= stopCmd && (phase == 2'h3);
      cpuWaitReq <= waitCmd && (phase == 2'h3);
      cpuMaskClear <= unmaskCmd && (phase == 2'h2);
    end
  end
endmodule // cpu_core_model

// ==== verification/test_irq_lowpower_control.sv ====
// Self-checking bench for the interrupt and low-power controller
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_irq_lowpower_control;
  // ==========================================================
  // Signals
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  irq_lowpower_pkg::axi_req_t axiReq = '0;
  irq_lowpower_pkg::axi_rsp_t axiRsp;
  logic [7:0] ev = 8'h00;
  logic canErr = 1'b0, canBus = 1'b0, canAsleep = 1'b0;
  logic [7:0] pinIn = 8'h00, pinOrEn = 8'h00;
  logic stopCmd = 1'b0, waitCmd = 1'b0, unmask = 1'b0, software_trap = 1'b0;
  logic instrDone, stopReq, waitReq, maskClr;
  logic can_irq, vectorLoad, irqMask, cpuClk, osc, tmrClk, wdog, pc;
  logic [15:0] vectorAddr;
  int pcs = 0;
  logic [31:0] d;
  logic [1:0] r, b;
  int errors = 0, n_compared = 0;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (pc === 1'b1) pcs <= pcs + 1;
  // ==========================================================
  // Design and core model
  irq_lowpower_control dut_u (.core_clk(core_clk), .srst(srst),
    .axiReq(axiReq), .axiRsp(axiRsp), .canRxDone(ev[0]),
    .canTxDone(ev[1]), .canErrStatus(canErr), .canBusStatus(canBus),
    .canOverrun(ev[2]), .canBusActivity(ev[3]), .canAsleep(canAsleep),
    .pinIn(pinIn), .pinOrEnable(pinOrEn), .coreTick(ev[7]),
    .captureEvent(ev[4]), .compareEvent(ev[5]), .timerWrapEvent(ev[6]),
    .cpuInstrDone(instrDone), .swiReq(software_trap), .cpuStopReq(stopReq),
    .cpuWaitReq(waitReq), .cpuMaskSet(1'b0), .cpuMaskClear(maskClr),
    .can_irq(can_irq), .vectorAddr(vectorAddr), .vectorLoad(vectorLoad),
    .irqMask(irqMask), .cpuClkEnable(cpuClk), .oscEnable(osc),
    .timerClkEnable(tmrClk), .watchdogRun(wdog), .prescalerClear(pc));
  cpu_core_model core_u (.core_clk(core_clk), .srst(srst),
    .cpuClkEnable(cpuClk), .stopCmd(stopCmd), .waitCmd(waitCmd),
    .unmaskCmd(unmask), .cpuInstrDone(instrDone), .cpuStopReq(stopReq),
    .cpuWaitReq(waitReq), .cpuMaskClear(maskClr));
  // ==========================================================
  // Bus, event and vector helpers
  task automatic wr(input logic [7:0] idx, input logic [7:0] v);
    @(posedge core_clk);
    axiReq.awvalid <= 1'b1;
    axiReq.awaddr <= {2'h0, idx, 2'h0};
    axiReq.wvalid <= 1'b1;
    axiReq.wdata <= {24'h0, v};
    axiReq.wstrb <= 4'hf;
    axiReq.bready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (axiRsp.awready) axiReq.awvalid <= 1'b0;
      if (axiRsp.wready) axiReq.wvalid <= 1'b0;
      if (axiRsp.bvalid) break;
    end
    b = axiRsp.bresp;
    axiReq.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] idx);
    @(posedge core_clk);
    axiReq.arvalid <= 1'b1;
    axiReq.araddr <= {2'h0, idx, 2'h0};
    axiReq.rready <= 1'b1;
    forever begin
      @(posedge core_clk);
      if (axiRsp.arready) axiReq.arvalid <= 1'b0;
      if (axiRsp.rvalid) break;
    end
    d = axiRsp.rdata;
    r = axiRsp.rresp;
    axiReq.rready <= 1'b0;
  endtask
  task automatic pulse(input int i, input int n);
    repeat (n) begin
      @(posedge core_clk) ev[i] <= 1'b1;
      @(posedge core_clk) ev[i] <= 1'b0;
    end
    @(posedge core_clk);
  endtask
  // Unmasks through the core and returns with the first vector taken
  task automatic takeVec();
    unmask <= 1'b1;
    for (int t = 0; t < 80; t++) begin
      @(posedge core_clk);
      if (vectorLoad === 1'b1) break;
    end
    unmask <= 1'b0;
  endtask
  task automatic lowPower(input logic stop);
    stopCmd <= stop;
    waitCmd <= !stop;
    for (int t = 0; t < 20; t++) @(posedge core_clk) if (!cpuClk) break;
    stopCmd <= 1'b0;
    waitCmd <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask
  task automatic done(input string s);
    $display("test %s finished", s);
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  task automatic testReset();
    `CHK({irqMask, vectorAddr}, 17'h11ffe)
    srst <= 1'b0;
    @(posedge core_clk);
    @(posedge core_clk);
    `CHK({vectorLoad, vectorAddr}, 17'h11ffe)
    @(posedge core_clk);
    `CHK({vectorLoad, vectorAddr, irqMask}, 18'h23fff)
    rd(8'h20);
    `CHK(d, 32'h01)
    rd(8'h08);
    `CHK(d, 32'h03)
    rd(8'h03);
    `CHK(d, 32'h00)
    rd(8'h30);
    `CHK({r, d}, 34'h200000000)
    wr(8'h30, 8'h55);
    `CHK(b, 2'h2)
    done("reset");
  endtask
  task automatic testCoreTimer();
    wr(8'h08, 8'h20);
    pulse(7, 255);
    rd(8'h08);
    `CHK(d[7], 1'b0)
    pulse(7, 1);
    rd(8'h08);
    `CHK(d[7], 1'b1)
    takeVec();
    `CHK({vectorLoad, vectorAddr}, 17'h11ff8)
    wr(8'h08, 8'h00);
    done("core timer");
  endtask
  task automatic testCan();
    int srcBit[4] = '{0, 1, 3, 4};
    wr(8'h20, 8'h1f);
    canAsleep <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      pulse(i, 1);
      `CHK(can_irq, 1'b1)
      rd(8'h23);
      `CHK(d, 32'h1 << srcBit[i])
    end
    canAsleep <= 1'b0;
    canErr <= 1'b1;
    rd(8'h23);
    `CHK(d, 32'h04)
    canBus <= 1'b1;
    rd(8'h23);
    `CHK(d, 32'h04)
    rd(8'h23);
    `CHK({can_irq, d}, 33'h0)
    wr(8'h20, 8'h01);
    pulse(0, 1);
    `CHK(can_irq, 1'b0)
    rd(8'h23);
    canAsleep <= 1'b1;
    pulse(3, 1);
    `CHK(can_irq, 1'b1)
    takeVec();
    `CHK({vectorLoad, vectorAddr}, 17'h11ffa)
    rd(8'h23);
    canAsleep <= 1'b0;
    done("can");
  endtask
  task automatic testPriority();
    wr(8'h20, 8'h03);
    wr(8'h12, 8'h80);
    pinOrEn <= 8'h01;
    pinIn <= 8'h02;
    repeat (8) @(posedge core_clk);
    rd(8'h03);
    `CHK(d, 32'h00)
    pinIn <= 8'h03;
    pulse(0, 1);
    pulse(4, 1);
    rd(8'h03);
    `CHK(d, 32'h20)
    takeVec();
    `CHK({vectorLoad, vectorAddr}, 17'h11ffa)
    rd(8'h23);
    takeVec();
    `CHK({vectorLoad, vectorAddr}, 17'h11ff6)
    wr(8'h03, 8'h00);
    rd(8'h03);
    `CHK({b, d}, 34'h0)
    takeVec();
    `CHK({vectorLoad, vectorAddr}, 17'h11ff4)
    for (int i = 1; i < 3; i++) begin
      wr(8'h13, 8'h00);
      wr(8'h12, 8'h80 >> i);
      pulse(4 + i, 1);
      takeVec();
      `CHK({vectorLoad, vectorAddr}, 17'h11ff4)
    end
    wr(8'h13, 8'h00);
    pinIn <= 8'h00;
    done("priority");
  endtask
  task automatic testStop();
    int pc0;
    wr(8'h08, 8'h32);
    wr(8'h12, 8'he0);
    canAsleep <= 1'b1;
    pc0 = pcs;
    lowPower(1'b1);
    `CHK({osc, tmrClk, wdog, irqMask, pcs == pc0 + 1}, 5'h01)
    rd(8'h08);
    `CHK(d, 32'h02)
    rd(8'h20);
    `CHK(d, 32'h03)
    pulse(4, 1);
    `CHK(cpuClk, 1'b0)
    pinIn <= 8'h01;
    takeVec();
    `CHK({vectorLoad, vectorAddr}, 17'h11ff6)
    wr(8'h03, 8'h00);
    canAsleep <= 1'b0;
    lowPower(1'b1);
    `CHK({osc, tmrClk, cpuClk}, 3'h4)
    pulse(0, 1);
    takeVec();
    `CHK({vectorLoad, vectorAddr}, 17'h11ffa)
    rd(8'h23);
    done("stop");
  endtask
  task automatic testWait();
    wr(8'h13, 8'h00);
    wr(8'h12, 8'h80);
    lowPower(1'b0);
    `CHK({cpuClk, tmrClk, osc, irqMask}, 4'h6)
    rd(8'h12);
    `CHK(d, 32'h80)
    pulse(4, 1);
    takeVec();
    `CHK({vectorLoad, vectorAddr}, 17'h11ff4)
    software_trap <= 1'b1;
    @(posedge core_clk);
    takeVec();
    `CHK({vectorLoad, vectorAddr}, 17'h11ffc)
    software_trap <= 1'b0;
    done("wait");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (16) @(posedge core_clk);
    testReset();
    testCoreTimer();
    testCan();
    testPriority();
    testStop();
    testWait();
    end_of_test();
  end
  initial begin
    #160000;
    errors++;
    end_of_test();
  end
endmodule // test_irq_lowpower_control
